// File: src/mixer_gain_mute_registers.sv
// Mixer gain, mute and capture source register bank
//
// Implementation choice: the plain strobed port.
module mixer_gain_mute_registers
  import mixer_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [6:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  output logic      [7:0]        mono_atten_o,
  output logic                   mono_out_silence_o,
  output logic signed [7:0]      phone_gain_o,
  output logic                   phone_silence_o,
  output logic signed [7:0]      mic_gain_o,
  output logic      [6:0]        mic_boost_o,
  output logic                   microphone_silence_o,
  output logic      [3:0][7:0]   stereo_left_gain_o,
  output logic      [3:0][7:0]   stereo_right_gain_o,
  output logic      [3:0]        stereo_left_silence_o,
  output logic      [3:0]        stereo_right_silence_o,
  output logic                   multi_from_pcm_o,
  output logic      [7:0]        multi_left_gain_o,
  output logic      [7:0]        multi_right_gain_o,
  output logic                   multi_left_silence_o,
  output logic                   multi_right_silence_o,
  output logic      [2:0]        left_capture_source_o,
  output logic      [2:0]        right_capture_source_o
);

  localparam int STEREO_N = 4;
  localparam int PCM_CH   = 3;

  // ***********************************************
  // Address decode
  // ***********************************************
  logic [5:0]          index;
  logic                sel_mono;
  logic                sel_phone;
  logic                sel_mic;
  logic                sel_capture;
  logic                sel_options;
  logic [STEREO_N-1:0] sel_stereo;

  // Low address bit ignored so odd indices alias down
  always_comb begin
    index          = addr_i[6:1];
    sel_mono       = (index == MONO_OFFSET[6:1]);
    sel_phone      = (index == PHONE_OFFSET[6:1]);
    sel_mic        = (index == MIC_OFFSET[6:1]);
    sel_capture    = (index == CAPTURE_OFFSET[6:1]);
    sel_options    = (index == OPTIONS_OFFSET[6:1]);
    sel_stereo[0]  = (index == LINE_OFFSET[6:1]);
    sel_stereo[1]  = (index == DISC_OFFSET[6:1]);
    sel_stereo[2]  = (index == AUX_OFFSET[6:1]);
    sel_stereo[3]  = (index == PLAYBACK_OFFSET[6:1]);
  end

  // ***********************************************
  // Mono, phone, mic, capture and option registers
  // ***********************************************
  logic       mono_out_silence, next_mono_out_silence;
  logic [4:0] mono_level_code, next_mono_level_code;
  logic       phone_silence, next_phone_silence;
  logic [4:0] phone_level_code, next_phone_level_code;
  logic       microphone_silence, next_microphone_silence;
  logic       microphone_boost_enable, next_microphone_boost_enable;
  logic [4:0] microphone_level_code, next_microphone_level_code;
  logic [2:0] left_capture_source, next_left_capture_source;
  logic [2:0] right_capture_source, next_right_capture_source;
  logic       split_silence_enable, next_split_silence_enable;
  logic       legacy_gain_mode, next_legacy_gain_mode;
  logic [1:0] boost_amount_select, next_boost_amount_select;

  // Writes store documented fields only; others dropped
  always_comb begin
    next_mono_out_silence        = mono_out_silence;
    next_mono_level_code         = mono_level_code;
    next_phone_silence           = phone_silence;
    next_phone_level_code        = phone_level_code;
    next_microphone_silence      = microphone_silence;
    next_microphone_boost_enable = microphone_boost_enable;
    next_microphone_level_code   = microphone_level_code;
    next_left_capture_source     = left_capture_source;
    next_right_capture_source    = right_capture_source;
    next_split_silence_enable    = split_silence_enable;
    next_legacy_gain_mode        = legacy_gain_mode;
    next_boost_amount_select     = boost_amount_select;
    if (wr_i && sel_mono) begin
      next_mono_out_silence = wdata_i[SILENCE_BIT];
      if (wdata_i[MONO_TOP_BIT]) begin
        next_mono_level_code = LEVEL_ALL_ONES;
      end else begin
        next_mono_level_code = wdata_i[4:0];
      end
    end
    if (wr_i && sel_phone) begin
      next_phone_silence    = wdata_i[SILENCE_BIT];
      next_phone_level_code = wdata_i[4:0];
    end
    if (wr_i && sel_mic) begin
      next_microphone_silence      = wdata_i[SILENCE_BIT];
      next_microphone_boost_enable = wdata_i[BOOST_BIT];
      next_microphone_level_code   = wdata_i[4:0];
    end
    if (wr_i && sel_capture) begin
      next_left_capture_source  = wdata_i[LEFT_SRC_LSB +: 3];
      next_right_capture_source = wdata_i[2:0];
    end
    if (wr_i && sel_options) begin
      next_split_silence_enable = wdata_i[SPLIT_BIT];
      next_legacy_gain_mode     = wdata_i[LEGACY_BIT];
      next_boost_amount_select  = wdata_i[1:0];
    end
  end

  // Register stage with documented reset values
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mono_out_silence        <= MONO_RESET[SILENCE_BIT];
      mono_level_code         <= MONO_RESET[4:0];
      phone_silence           <= MONO_IN_RESET[SILENCE_BIT];
      phone_level_code        <= MONO_IN_RESET[4:0];
      microphone_silence      <= MONO_IN_RESET[SILENCE_BIT];
      microphone_boost_enable <= MONO_IN_RESET[BOOST_BIT];
      microphone_level_code   <= MONO_IN_RESET[4:0];
      left_capture_source     <= CAPTURE_RESET[LEFT_SRC_LSB +: 3];
      right_capture_source    <= CAPTURE_RESET[2:0];
      split_silence_enable    <= OPTIONS_RESET[SPLIT_BIT];
      legacy_gain_mode        <= OPTIONS_RESET[LEGACY_BIT];
      boost_amount_select     <= OPTIONS_RESET[1:0];
    end else begin
      mono_out_silence        <= next_mono_out_silence;
      mono_level_code         <= next_mono_level_code;
      phone_silence           <= next_phone_silence;
      phone_level_code        <= next_phone_level_code;
      microphone_silence      <= next_microphone_silence;
      microphone_boost_enable <= next_microphone_boost_enable;
      microphone_level_code   <= next_microphone_level_code;
      left_capture_source     <= next_left_capture_source;
      right_capture_source    <= next_right_capture_source;
      split_silence_enable    <= next_split_silence_enable;
      legacy_gain_mode        <= next_legacy_gain_mode;
      boost_amount_select     <= next_boost_amount_select;
    end
  end

  // ***********************************************
  // Stereo registers and gain mapping
  // ***********************************************
  logic [STEREO_N-1:0][15:0]      stereo_value;
  logic [STEREO_N-1:0][4:0]       stereo_left_level;
  logic [STEREO_N-1:0][4:0]       stereo_right_level;
  logic [STEREO_N-1:0]            stereo_left_mute;
  logic [STEREO_N-1:0]            stereo_right_mute;
  logic [STEREO_N-1:0][7:0]       left_gain;
  logic [STEREO_N-1:0][7:0]       right_gain;
  logic signed [7:0]              phone_gain;
  logic signed [7:0]              mic_gain;

  // Line, disc, auxiliary and playback channels
  for (genvar ch = 0; ch < STEREO_N; ch++) begin : g_stereo
    stereo_level_reg u_reg (
      .clk_i           (clk_i),
      .resetn_i        (resetn_i),
      .wr_i            (wr_i & sel_stereo[ch]),
      .wdata_i         (wdata_i),
      .split_i         (split_silence_enable),
      .value_o         (stereo_value[ch]),
      .left_level_o    (stereo_left_level[ch]),
      .right_level_o   (stereo_right_level[ch]),
      .left_silence_o  (stereo_left_mute[ch]),
      .right_silence_o (stereo_right_mute[ch])
    );
    gain_code_map u_left (
      .code_i (stereo_left_level[ch]),
      .gain_o (left_gain[ch])
    );
    gain_code_map u_right (
      .code_i (stereo_right_level[ch]),
      .gain_o (right_gain[ch])
    );
  end

  // Mono input channels share the stereo code points
  gain_code_map u_phone_gain (
    .code_i (phone_level_code),
    .gain_o (phone_gain)
  );
  gain_code_map u_mic_gain (
    .code_i (microphone_level_code),
    .gain_o (mic_gain)
  );

  // ***********************************************
  // Registered outputs and read data
  // ***********************************************
  logic [15:0]          next_rdata;
  logic [7:0]           next_mono_atten;
  logic [6:0]           next_mic_boost;
  logic                 next_multi_from_pcm;
  logic [7:0]           next_multi_left_gain;
  logic [7:0]           next_multi_right_gain;
  logic                 next_multi_left_silence;
  logic                 next_multi_right_silence;

  // Output decode and read mux; unmapped reads return zero
  always_comb begin
    next_mono_atten = 8'({3'h0, mono_level_code} * STEP_HALF_DB);
    case (boost_amount_select)
      BOOST_SEL_10: next_mic_boost = BOOST_10_HALF;
      BOOST_SEL_30: next_mic_boost = BOOST_30_HALF;
      default:      next_mic_boost = BOOST_20_HALF;
    endcase
    if (!microphone_boost_enable) begin
      next_mic_boost = 7'h00;
    end
    next_multi_from_pcm      = !legacy_gain_mode;
    next_multi_left_gain     = 8'h00;
    next_multi_right_gain    = 8'h00;
    next_multi_left_silence  = 1'b0;
    next_multi_right_silence = 1'b0;
    if (!legacy_gain_mode) begin
      next_multi_left_gain     = left_gain[PCM_CH];
      next_multi_right_gain    = right_gain[PCM_CH];
      next_multi_left_silence  = stereo_left_mute[PCM_CH];
      next_multi_right_silence = stereo_right_mute[PCM_CH];
    end
    next_rdata = 16'h0000;
    if (rd_i) begin
      if (sel_mono) begin
        next_rdata              = {11'h000, mono_level_code};
        next_rdata[SILENCE_BIT] = mono_out_silence;
      end else if (sel_phone) begin
        next_rdata              = {11'h000, phone_level_code};
        next_rdata[SILENCE_BIT] = phone_silence;
      end else if (sel_mic) begin
        next_rdata              = {11'h000, microphone_level_code};
        next_rdata[SILENCE_BIT] = microphone_silence;
        next_rdata[BOOST_BIT]   = microphone_boost_enable;
      end else if (sel_capture) begin
        next_rdata[LEFT_SRC_LSB +: 3] = left_capture_source;
        next_rdata[2:0]               = right_capture_source;
      end else if (sel_options) begin
        next_rdata[SPLIT_BIT]  = split_silence_enable;
        next_rdata[LEGACY_BIT] = legacy_gain_mode;
        next_rdata[1:0]        = boost_amount_select;
      end else begin
        for (int i = 0; i < STEREO_N; i++) begin
          if (sel_stereo[i]) begin
            next_rdata = stereo_value[i];
          end
        end
      end
    end
  end

  // Output register stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_o                <= 16'h0000;
      mono_atten_o           <= 8'h00;
      mono_out_silence_o     <= 1'b1;
      phone_gain_o           <= 8'sh00;
      phone_silence_o        <= 1'b1;
      mic_gain_o             <= 8'sh00;
      mic_boost_o            <= 7'h00;
      microphone_silence_o   <= 1'b1;
      stereo_left_gain_o     <= '0;
      stereo_right_gain_o    <= '0;
      stereo_left_silence_o  <= '1;
      stereo_right_silence_o <= '1;
      multi_from_pcm_o       <= 1'b1;
      multi_left_gain_o      <= 8'h00;
      multi_right_gain_o     <= 8'h00;
      multi_left_silence_o   <= 1'b1;
      multi_right_silence_o  <= 1'b1;
      left_capture_source_o  <= SRC_MIC;
      right_capture_source_o <= SRC_MIC;
    end else begin
      rdata_o                <= next_rdata;
      mono_atten_o           <= next_mono_atten;
      mono_out_silence_o     <= mono_out_silence;
      phone_gain_o           <= phone_gain;
      phone_silence_o        <= phone_silence;
      mic_gain_o             <= mic_gain;
      mic_boost_o            <= next_mic_boost;
      microphone_silence_o   <= microphone_silence;
      stereo_left_gain_o     <= left_gain;
      stereo_right_gain_o    <= right_gain;
      stereo_left_silence_o  <= stereo_left_mute;
      stereo_right_silence_o <= stereo_right_mute;
      multi_from_pcm_o       <= next_multi_from_pcm;
      multi_left_gain_o      <= next_multi_left_gain;
      multi_right_gain_o     <= next_multi_right_gain;
      multi_left_silence_o   <= next_multi_left_silence;
      multi_right_silence_o  <= next_multi_right_silence;
      left_capture_source_o  <= left_capture_source;
      right_capture_source_o <= right_capture_source;
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_line_right_write;
    wr_i && sel_stereo[0] && split_silence_enable
      && wdata_i[RIGHT_MUTE_BIT] && !wdata_i[SILENCE_BIT];
  endsequence

  sequence s_line_quiet;
    !(wr_i && sel_stereo[0]) && !(wr_i && sel_options);
  endsequence

  chk_mono_force_ones: assert property (
    wr_i && sel_mono && wdata_i[MONO_TOP_BIT] |=> mono_level_code == 5'h1f
  ) else $error("mono level not forced to all ones");

  chk_mono_step_size: assert property (
    ##1 mono_atten_o == 8'($past(mono_level_code) * 3)
  ) else $error("mono attenuation not 1.5 dB per step");

  chk_mono_silence: assert property (
    wr_i && sel_mono && wdata_i[SILENCE_BIT] |=> ##1 mono_out_silence_o
  ) else $error("mono output not silenced");

  chk_phone_code_points: assert property (
    (phone_level_code == 5'h00 |=> phone_gain_o == 8'sd24)
    and (phone_level_code == 5'h1f |=> phone_gain_o == -8'sd69)
  ) else $error("phone gain code points wrong");

  chk_mic_boost_amount: assert property (
    microphone_boost_enable && boost_amount_select == 2'h1 |=> mic_boost_o == 7'd20
  ) else $error("mic boost amount wrong");

  chk_split_off_read: assert property (
    rd_i && sel_stereo[0] && !split_silence_enable |=> !rdata_o[RIGHT_MUTE_BIT]
  ) else $error("right mute bit read back while split off");

  chk_split_right_only: assert property (
    s_line_right_write ##1 s_line_quiet |=> stereo_right_silence_o[0] && !stereo_left_silence_o[0]
  ) else $error("split mute did not act on right only");

  chk_legacy_follow: assert property (
    ##1 (multi_from_pcm_o == !$past(legacy_gain_mode))
    && (!multi_from_pcm_o || multi_left_gain_o == stereo_left_gain_o[PCM_CH])
  ) else $error("multichannel gain does not follow playback");

  chk_odd_alias: assert property (
    wr_i && addr_i == 7'h0d |=> phone_level_code == $past(wdata_i[4:0])
  ) else $error("odd index did not alias to even");

  chk_reserved_zero: assert property (
    rd_i && sel_capture |=> rdata_o[15:11] == 5'h00 && rdata_o[7:3] == 5'h00
  ) else $error("reserved capture bits not zero");

endmodule // mixer_gain_mute_registers

// File: src/mixer_pkg.sv
// Constants for the mixer gain and mute register bank
// Summary of operation
// - Mono top level bit forces low five ones
// - Mono code adds 1.5 dB attenuation per step
// - Mono silence bit mutes regardless of level
// - Phone level: five bits, +12 to -34.5 dB
// - Codes 00000/01000/11111 give +12/0/-34.5 dB
// - Phone and mic reset: 0 dB, muted
// - Phone silence bit mutes phone channel
// - Mic level uses phone gain range
// - Mic boost 0 or 20 dB, selectable 10/30
// - Mic silence bit mutes mic channel
// - Stereo registers hold five-bit left, right levels
// - Split off: top bit mutes both, D7 reads 0
// - Split on: top bit left, D7 right
// - Stereo reset: 0 dB both channels, muted
// - Legacy mode clear: playback drives multichannel DACs
// - Capture select: two three-bit fields, reset microphone
// - Capture codes map to the eight sources
// - Odd index aliases next lower even index
package mixer_pkg;

  // ***********************************************
  // Register indices (7-bit register index space)
  // ***********************************************
  localparam logic [6:0]  MONO_OFFSET     = 7'h06;
  localparam logic [6:0]  PHONE_OFFSET    = 7'h0c;
  localparam logic [6:0]  MIC_OFFSET      = 7'h0e;
  localparam logic [6:0]  LINE_OFFSET     = 7'h10;
  localparam logic [6:0]  DISC_OFFSET     = 7'h12;
  localparam logic [6:0]  AUX_OFFSET      = 7'h16;
  localparam logic [6:0]  PLAYBACK_OFFSET = 7'h18;
  localparam logic [6:0]  CAPTURE_OFFSET  = 7'h1a;
  localparam logic [6:0]  OPTIONS_OFFSET  = 7'h76;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [15:0] MONO_RESET      = 16'h8000;
  localparam logic [15:0] MONO_IN_RESET   = 16'h8008;
  localparam logic [15:0] STEREO_RESET    = 16'h8808;
  localparam logic [15:0] CAPTURE_RESET   = 16'h0000;
  localparam logic [15:0] OPTIONS_RESET   = 16'h0000;

  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int          SILENCE_BIT     = 15;
  localparam int          RIGHT_MUTE_BIT  = 7;
  localparam int          MONO_TOP_BIT    = 5;
  localparam int          BOOST_BIT       = 6;
  localparam int          LEFT_LSB        = 8;
  localparam int          LEFT_SRC_LSB    = 8;
  localparam int          LEGACY_BIT      = 14;
  localparam int          SPLIT_BIT       = 13;

  // ***********************************************
  // Gain arithmetic in half-dB units
  // ***********************************************
  localparam logic signed [7:0] STEP_HALF_DB   = 8'sh03;
  localparam logic signed [7:0] UNITY_CODE     = 8'sh08;
  localparam logic [4:0]        LEVEL_ALL_ONES = 5'h1f;

  // Boost amounts in half-dB units and their selector codes
  localparam logic [1:0]  BOOST_SEL_20    = 2'h0;
  localparam logic [1:0]  BOOST_SEL_10    = 2'h1;
  localparam logic [1:0]  BOOST_SEL_30    = 2'h2;
  localparam logic [6:0]  BOOST_10_HALF   = 7'h14;
  localparam logic [6:0]  BOOST_20_HALF   = 7'h28;
  localparam logic [6:0]  BOOST_30_HALF   = 7'h3c;

  // Capture source codes
  localparam logic [2:0]  SRC_MIC         = 3'h0;
  localparam logic [2:0]  SRC_DISC        = 3'h1;
  localparam logic [2:0]  SRC_MUTED       = 3'h2;
  localparam logic [2:0]  SRC_AUX         = 3'h3;
  localparam logic [2:0]  SRC_LINE        = 3'h4;
  localparam logic [2:0]  SRC_STEREO_MIX  = 3'h5;
  localparam logic [2:0]  SRC_MONO_MIX    = 3'h6;
  localparam logic [2:0]  SRC_PHONE       = 3'h7;

endpackage

// File: src/gain_code_map.sv
// Maps a five-bit level code to a signed gain in half-dB units
module gain_code_map
  import mixer_pkg::*;
(
  input  wire logic        [4:0] code_i,
  output logic signed      [7:0] gain_o
);

  logic signed [7:0] steps;

  // Code 8 is unity; each code step is 1.5 dB
  always_comb begin
    steps  = UNITY_CODE - $signed({3'h0, code_i});
    gain_o = 8'(steps * STEP_HALF_DB);
  end

endmodule // gain_code_map

// File: src/stereo_level_reg.sv
// One stereo level register with optional split left/right mute
module stereo_level_reg
  import mixer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        split_i,
  output logic      [15:0] value_o,
  output logic      [4:0]  left_level_o,
  output logic      [4:0]  right_level_o,
  output logic             left_silence_o,
  output logic             right_silence_o
);

  logic       silence, next_silence;
  logic       right_mute, next_right_mute;
  logic [4:0] left_lvl, next_left_lvl;
  logic [4:0] right_lvl, next_right_lvl;

  // Next values: only documented fields are stored
  always_comb begin
    next_silence    = silence;
    next_right_mute = right_mute;
    next_left_lvl   = left_lvl;
    next_right_lvl  = right_lvl;
    if (wr_i) begin
      next_silence    = wdata_i[SILENCE_BIT];
      next_right_mute = wdata_i[RIGHT_MUTE_BIT];
      next_left_lvl   = wdata_i[LEFT_LSB +: 5];
      next_right_lvl  = wdata_i[4:0];
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      silence    <= STEREO_RESET[SILENCE_BIT];
      right_mute <= STEREO_RESET[RIGHT_MUTE_BIT];
      left_lvl   <= STEREO_RESET[LEFT_LSB +: 5];
      right_lvl  <= STEREO_RESET[4:0];
    end else begin
      silence    <= next_silence;
      right_mute <= next_right_mute;
      left_lvl   <= next_left_lvl;
      right_lvl  <= next_right_lvl;
    end
  end

  // Readback and effective mutes
  always_comb begin
    value_o                  = 16'h0000;
    value_o[SILENCE_BIT]     = silence;
    value_o[RIGHT_MUTE_BIT]  = split_i & right_mute;
    value_o[LEFT_LSB +: 5]   = left_lvl;
    value_o[4:0]             = right_lvl;
    left_level_o             = left_lvl;
    right_level_o            = right_lvl;
    left_silence_o           = silence;
    right_silence_o          = split_i ? right_mute : silence;
  end

endmodule // stereo_level_reg

// File: test/host_model.sv
// Host controller model driving the register port of the mixer bank
module host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic      [6:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    addr_o  = 7'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // One-cycle write, reserved bits left to the caller as zeros
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule // host_model

// File: test/mixer_gain_mute_registers_test.sv
// Self-checking bench for the mixer gain and mute register bank
module mixer_gain_mute_registers_test;
  timeunit 1ns;
  timeprecision 100ps;
  import mixer_pkg::*;
  logic clk, resetn, wr, rd, mono_sil, phone_sil, mic_sil, m_from, ml_sil, mr_sil;
  logic [6:0] addr, mic_boost;
  logic [15:0] wdata, rdata;
  logic [7:0] mono_atten, ml_gain, mr_gain;
  logic signed [7:0] phone_gain, mic_gain;
  logic [3:0][7:0] sl_gain, sr_gain;
  logic [3:0] sl_sil, sr_sil;
  logic [2:0] lcap, rcap;
  int bad_count = 0;
  int checks_done = 0;
  logic [6:0] adr_tab [8] = '{MONO_OFFSET, PHONE_OFFSET, MIC_OFFSET, LINE_OFFSET, DISC_OFFSET, AUX_OFFSET,
                              PLAYBACK_OFFSET, CAPTURE_OFFSET};
  logic [15:0] rst_tab [8] = '{16'h8000, 16'h8008, 16'h8008, 16'h8808, 16'h8808, 16'h8808, 16'h8808, 16'h0000};
  logic [7:0] boost_tab [3] = '{8'h14, 8'h3c, 8'h28};
  host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  mixer_gain_mute_registers uut (.clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .mono_atten_o(mono_atten), .mono_out_silence_o(mono_sil),
    .phone_gain_o(phone_gain), .phone_silence_o(phone_sil), .mic_gain_o(mic_gain), .mic_boost_o(mic_boost),
    .microphone_silence_o(mic_sil), .stereo_left_gain_o(sl_gain), .stereo_right_gain_o(sr_gain),
    .stereo_left_silence_o(sl_sil), .stereo_right_silence_o(sr_sil), .multi_from_pcm_o(m_from),
    .multi_left_gain_o(ml_gain), .multi_right_gain_o(mr_gain), .multi_left_silence_o(ml_sil),
    .multi_right_silence_o(mr_sil), .left_capture_source_o(lcap), .right_capture_source_o(rcap));
  // ***********************************************
  // Compare and sequencing helpers
  // ***********************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd_reg(a, d);
    chk("rdata", exp, d);
  endtask
  // Decoded outputs land one edge after the write
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rchk(adr_tab[i], rst_tab[i]);
    rchk(7'h00, 16'h0000);
    chk("reset_sil", 16'h1fff, {3'h0, mono_sil, phone_sil, mic_sil, ml_sil, mr_sil, sl_sil, sr_sil});
    host.wr_reg(MONO_OFFSET, 16'h0020);
    settle;
    chk("mono", 16'h005d, {7'h00, mono_sil, mono_atten});
    rchk(MONO_OFFSET, 16'h001f);
    host.wr_reg(PHONE_OFFSET | 7'h01, 16'h0000);
    settle;
    chk("phone", 16'h0018, {7'h00, phone_sil, phone_gain});
    host.wr_reg(MIC_OFFSET, 16'h005f);
    settle;
    chk("mic", 16'h00bb, {7'h00, mic_sil, mic_gain});
    chk("boost", 16'h0028, {9'h000, mic_boost});
    rchk(MIC_OFFSET, 16'h005f);
    for (int i = 0; i < 3; i++) begin
      host.wr_reg(OPTIONS_OFFSET, 16'(i + 1));
      settle;
      chk("boost", {8'h00, boost_tab[i]}, {9'h000, mic_boost});
    end
    host.wr_reg(DISC_OFFSET | 7'h01, 16'h9f80);
    settle;
    chk("disc", 16'h03bb, {6'h00, sl_sil[1], sr_sil[1], sl_gain[1]});
    chk("disc_r", 16'h0018, {8'h00, sr_gain[1]});
    rchk(DISC_OFFSET, 16'h9f00);
    host.wr_reg(OPTIONS_OFFSET, 16'h2000);
    settle;
    rchk(DISC_OFFSET, 16'h9f80);
    host.wr_reg(LINE_OFFSET, 16'h0080);
    host.wr_reg(DISC_OFFSET, 16'h0080);
    settle;
    chk("split_sil", 16'h0005, {12'h000, sl_sil[0], sr_sil[0], sl_sil[1], sr_sil[1]});
    host.wr_reg(PLAYBACK_OFFSET, 16'h0402);
    settle;
    chk("multi", 16'h040c, {5'h00, m_from, ml_sil, mr_sil, ml_gain});
    chk("multi_r", 16'h0012, {8'h00, mr_gain});
    host.wr_reg(OPTIONS_OFFSET, 16'h4000);
    settle;
    chk("multi", 16'h000c, {5'h00, m_from, ml_sil, mr_sil, sl_gain[3]});
    chk("multi_gain", 16'h0000, {ml_gain, mr_gain});
    for (int c = 0; c < 8; c++) begin
      host.wr_reg(CAPTURE_OFFSET, {5'h00, 3'(c), 5'h00, 3'(7 - c)});
      settle;
      chk("capture", {5'h00, 3'(c), 5'h00, 3'(7 - c)}, {5'h00, lcap, 5'h00, rcap});
    end
    host.wr_reg(CAPTURE_OFFSET, 16'hffff);
    rchk(CAPTURE_OFFSET, 16'h0707);
    end_sim;
  end
endmodule // mixer_gain_mute_registers_test
